/* core/mmcs_modem_mode.sv */
`timescale 1ns/10ps
`include "mmcs_map.svh"

// Small synchronous FIFO; the drain side may stall so it really fills.
module mmcs_fifo #(
  parameter int WIDTH = `MMCS_FIFO_W,
  parameter int DEPTH = `MMCS_FIFO_D
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit.
  assign inReady  = !((wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]));
  assign outValid = (wrPtr_r != rdPtr_r);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_r[AW-1:0]];

  // Storage array is written on every accepted word.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  // Pointer advance.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end
endmodule

// Mode command and status logic of the line modem.
module mmcs_modem_mode
  import mmcs_pkg::*;
#(
  parameter logic [63:0] WD_CYC    = `MMCS_WD_TIME_S * `MMCS_CLK_HZ,
  parameter logic [63:0] RETRY_CYC = `MMCS_RETRY_MIN * `MMCS_SEC_PER_MIN * `MMCS_CLK_HZ
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] powerUpSettings,
  input  wire logic        rackCmdWrite,
  input  wire logic [15:0] rackCmdData,
  input  wire logic        portCmdWrite,
  input  wire logic [15:0] portCmdData,
  input  wire logic        lineCmdWrite,
  input  wire logic [15:0] lineCmdData,
  output logic [15:0]      modeCommandWord,
  output logic [15:0]      modeStateWord,
  output logic [15:0]      errorFlags,
  output logic             setupDefaulted,
  input  wire logic        carrierDetect,
  input  wire logic        clearToSend,
  input  wire logic        dialInput,
  input  wire logic        dialFailed,
  input  wire logic        hangupRequest,
  input  wire logic        ringing,
  input  wire logic        ringPulse,
  input  wire logic [7:0]  ringsToAnswer,
  input  wire logic        atDetectValid,
  input  wire logic [1:0]  atDetectParity,
  output logic             pushTalkRelay,
  output logic             rtsEnable,
  output logic             offHook,
  output logic             autoDialRequest,
  output logic             leasedAnswerMode,
  output logic             carrierSeqStart,
  output mmcs_par_type     portParity,
  output mmcs_par_type     lineParity,
  output logic             portCrc,
  output logic             lineCrc,
  input  wire logic        dropValid,
  output logic             dropReady,
  input  wire logic [7:0]  dropData,
  input  wire logic        dropLast,
  input  wire logic        dropFromLine,
  input  wire logic [7:0]  hopCount,
  output logic             verdictValid,
  input  wire logic        verdictReady,
  output logic             verdictLocal,
  output logic             verdictToLine
);
  logic [15:0]  set_r;
  logic [15:0]  set_nxt;
  logic [15:0]  rackCopy_r;
  logic [15:0]  portCopy_r;
  logic [15:0]  lineCopy_r;
  logic         loaded_r;
  logic         mdropEff;
  logic         dialUp;
  logic         offHook_r;
  logic [7:0]   ringCnt_r;
  logic         dialPrev_r;
  mmcs_wd_type  wd_r;
  logic [63:0]  wdCnt_r;
  logic         autoDial_r;
  logic         seqStart_r;
  logic [15:0]  state_r;
  logic [1:0]   atPar_r;
  logic         fValid;
  logic         fReady;
  logic [9:0]   fData;
  logic [7:0]   prevDrop_r;
  logic         vValid_r;
  logic         vLocal_r;
  logic         vToLine_r;
  logic [1:0]   pField;
  logic [1:0]   lField;

  assign dialUp   = !set_r[`MMCS_B_LEASED];
  // Multidrop only with transparent mode on a leased circuit.
  assign mdropEff = set_r[`MMCS_B_MDROP] && set_r[`MMCS_B_TRANSP] && !dialUp;

  // Apply only the bits each source has changed since its own last write.
  always_comb begin
    set_nxt = set_r;
    if (lineCmdWrite) begin
      set_nxt = (set_nxt & ~((lineCmdData ^ lineCopy_r) & `MMCS_CMD_MASK))
              | (lineCmdData & (lineCmdData ^ lineCopy_r) & `MMCS_CMD_MASK);
    end
    if (portCmdWrite) begin
      set_nxt = (set_nxt & ~((portCmdData ^ portCopy_r) & `MMCS_CMD_MASK))
              | (portCmdData & (portCmdData ^ portCopy_r) & `MMCS_CMD_MASK);
    end
    if (rackCmdWrite) begin
      set_nxt = (set_nxt & ~((rackCmdData ^ rackCopy_r) & `MMCS_CMD_MASK))
              | (rackCmdData & (rackCmdData ^ rackCopy_r) & `MMCS_CMD_MASK);
    end
    // Leaving the leased circuit for dial-up drops a multidrop selection.
    if (set_r[`MMCS_B_LEASED] && !set_nxt[`MMCS_B_LEASED]) begin
      set_nxt[`MMCS_B_MDROP] = 1'b0;
    end
  end

  // Settings register, loaded once after reset release from stored setup.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      set_r          <= `MMCS_DEFAULT_SET;
      loaded_r       <= 1'b0;
      setupDefaulted <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      if (powerUpSettings[`MMCS_B_MDROP] && !powerUpSettings[`MMCS_B_TRANSP]) begin
        set_r          <= `MMCS_DEFAULT_SET;
        setupDefaulted <= 1'b1;
      end else begin
        set_r <= powerUpSettings & `MMCS_CMD_MASK;
      end
    end else begin
      set_r <= set_nxt;
    end
  end

  // Per-source copies of the last written command word.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rackCopy_r <= `MMCS_DEFAULT_SET;
      portCopy_r <= `MMCS_DEFAULT_SET;
      lineCopy_r <= `MMCS_DEFAULT_SET;
    end else begin
      if (rackCmdWrite) begin
        rackCopy_r <= rackCmdData;
      end
      if (portCmdWrite) begin
        portCopy_r <= portCmdData;
      end
      if (lineCmdWrite) begin
        lineCopy_r <= lineCmdData;
      end
    end
  end

  // Last parity seen by the AT interpreter, used in transparent mode.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      atPar_r <= 2'b00;
    end else if (!set_r[`MMCS_B_TRANSP]) begin
      atPar_r <= {set_r[`MMCS_B_PPAR_LO], set_r[`MMCS_B_PPAR_HI]};
    end else if (atDetectValid) begin
      atPar_r <= atDetectParity;
    end
  end

  // Field codes are {none bit, odd bit}; the line copies the port in transparent mode.
  assign pField = set_r[`MMCS_B_TRANSP] ? atPar_r
                : {set_r[`MMCS_B_PPAR_LO], set_r[`MMCS_B_PPAR_HI]};
  assign lField = set_r[`MMCS_B_TRANSP] ? pField
                : {set_r[`MMCS_B_LPAR_LO], set_r[`MMCS_B_LPAR_HI]};

  // Parity decode with fallback to even on the invalid code.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      portParity <= PAR_EVEN;
      lineParity <= PAR_EVEN;
      errorFlags <= 16'h0000;
    end else begin
      portParity <= pField[1] ? (pField[0] ? PAR_EVEN : PAR_NONE)
                              : (pField[0] ? PAR_ODD : PAR_EVEN);
      lineParity <= lField[1] ? (lField[0] ? PAR_EVEN : PAR_NONE)
                              : (lField[0] ? PAR_ODD : PAR_EVEN);
      errorFlags <= 16'h0000;
      errorFlags[`MMCS_ERR_PPAR] <= &pField;
      errorFlags[`MMCS_ERR_LPAR] <= &lField;
    end
  end

  // Plain configuration outputs.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pushTalkRelay    <= 1'b0;
      rtsEnable        <= 1'b0;
      portCrc          <= 1'b0;
      lineCrc          <= 1'b0;
      leasedAnswerMode <= 1'b0;
      modeCommandWord  <= 16'h0000;
    end else begin
      pushTalkRelay    <= set_r[`MMCS_B_PTT];
      rtsEnable        <= set_r[`MMCS_B_RTS];
      portCrc          <= set_r[`MMCS_B_PCRC];
      lineCrc          <= set_r[`MMCS_B_LCRC];
      leasedAnswerMode <= !dialUp && !set_r[`MMCS_B_AAOFF];
      modeCommandWord  <= set_r;
    end
  end

  // Leased originator holds the carrier sequence request for as long as no carrier is detected.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seqStart_r <= 1'b0;
    end else begin
      seqStart_r <= !dialUp && set_r[`MMCS_B_AAOFF] && !carrierDetect;
    end
  end
  assign carrierSeqStart = seqStart_r;

  // Ring counting and hook control on the dial-up line.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      offHook_r  <= 1'b0;
      ringCnt_r  <= 8'h00;
    end else begin
      if (!ringing || offHook_r) begin
        ringCnt_r <= 8'h00;
      end else if (ringPulse) begin
        ringCnt_r <= ringCnt_r + 8'h01;
      end
      if (!dialUp || hangupRequest) begin
        offHook_r <= 1'b0;
      end else if (autoDial_r) begin
        offHook_r <= 1'b1;
      end else if (ringing && !set_r[`MMCS_B_AAOFF] && (ringsToAnswer != 8'h00)
                   && (ringCnt_r >= ringsToAnswer)) begin
        offHook_r <= 1'b1;
      end
    end
  end
  assign offHook = offHook_r;

  // Watchdog over the dial input with timed dialing and retries.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wd_r       <= WD_IDLE;
      wdCnt_r    <= 64'h0;
      autoDial_r <= 1'b0;
      dialPrev_r <= 1'b0;
    end else begin
      dialPrev_r <= dialInput;
      autoDial_r <= 1'b0;
      if (!set_r[`MMCS_B_WDOG]) begin
        wd_r    <= WD_IDLE;
        wdCnt_r <= 64'h0;
      end else begin
        unique case (wd_r)
          WD_IDLE: begin
            if (dialInput != dialPrev_r) begin
              wdCnt_r <= 64'h0;
            end else if (wdCnt_r >= WD_CYC - 64'h1) begin
              wdCnt_r    <= 64'h0;
              autoDial_r <= 1'b1;
              wd_r       <= WD_DIAL;
            end else begin
              wdCnt_r <= wdCnt_r + 64'h1;
            end
          end
          WD_DIAL: begin
            if (carrierDetect) begin
              wd_r <= WD_LINK;
            end else if (dialFailed) begin
              wdCnt_r <= 64'h0;
              wd_r    <= WD_RETRY;
            end
          end
          WD_LINK: begin // Carrier holds the link; the dial input is ignored.
            if (!carrierDetect) begin
              wdCnt_r <= 64'h0;
              wd_r    <= WD_RETRY;
            end
          end
          WD_RETRY: begin
            if (wdCnt_r >= RETRY_CYC - 64'h1) begin
              wdCnt_r    <= 64'h0;
              autoDial_r <= 1'b1;
              wd_r       <= WD_DIAL;
            end else begin
              wdCnt_r <= wdCnt_r + 64'h1;
            end
          end
        endcase
      end
    end
  end
  assign autoDialRequest = autoDial_r;

  // Status word mirrors the live settings and line state.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= 16'h0000;
    end else begin
      state_r                    <= set_r;
      state_r[`MMCS_B_DIAL]      <= carrierDetect;
      state_r[`MMCS_B_RTS]       <= clearToSend;
      state_r[`MMCS_B_MDROP]     <= mdropEff;
      state_r[`MMCS_B_WDOG]      <= dialInput;
      state_r[`MMCS_B_TWOWIRE]   <= dialUp ? offHook_r : set_r[`MMCS_B_TWOWIRE];
      state_r[`MMCS_B_RING]      <= dialUp && ringing && !offHook_r;
    end
  end
  assign modeStateWord = state_r;

  // Route drops pass through a small FIFO ahead of the classifier.
  mmcs_fifo #(
    .WIDTH (`MMCS_FIFO_W),
    .DEPTH (`MMCS_FIFO_D)
  ) u_dropFifo (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inValid  (dropValid),
    .inReady  (dropReady),
    .inData   ({dropFromLine, dropLast, dropData}),
    .outValid (fValid),
    .outReady (fReady),
    .outData  (fData)
  );

  // The classifier stalls the FIFO while a verdict waits to be taken.
  assign fReady = !vValid_r || verdictReady;

  // Verdict per packet: local execution or forward to the other port.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prevDrop_r <= 8'h00;
      vValid_r   <= 1'b0;
      vLocal_r   <= 1'b0;
      vToLine_r  <= 1'b0;
    end else begin
      if (vValid_r && verdictReady) begin
        vValid_r <= 1'b0;
      end
      if (fValid && fReady) begin
        prevDrop_r <= fData[7:0];
        if (fData[8]) begin
          vValid_r  <= 1'b1;
          vToLine_r <= !fData[9];
          vLocal_r  <= !set_r[`MMCS_B_TRANSP] && (
                       (!fData[9] && fData[7:0] == `MMCS_DROP_SERIAL) ||
                       (fData[9] && fData[7:0] == `MMCS_DROP_LINE) ||
                       (fData[7:0] == `MMCS_DROP_HOPS && prevDrop_r == hopCount));
          prevDrop_r <= 8'h00;
        end
      end
    end
  end
  assign verdictValid  = vValid_r;
  assign verdictLocal  = vLocal_r;
  assign verdictToLine = vToLine_r;
endmodule

/* core/mmcs_map.svh */
`ifndef MMCS_MAP_SVH
`define MMCS_MAP_SVH
`define MMCS_B_DIAL      0
`define MMCS_B_RTS       1
`define MMCS_B_MDROP     2
`define MMCS_B_TRANSP    3
`define MMCS_B_AAOFF     4
`define MMCS_B_PTT       5
`define MMCS_B_WDOG      6
`define MMCS_B_PPAR_LO   7
`define MMCS_B_PPAR_HI   8
`define MMCS_B_LPAR_LO   9
`define MMCS_B_LPAR_HI   10
`define MMCS_B_PCRC      11
`define MMCS_B_LCRC      12
`define MMCS_B_LEASED    13
`define MMCS_B_TWOWIRE   14
`define MMCS_B_RING      15
`define MMCS_CMD_MASK    16'h7fff
`define MMCS_DEFAULT_SET 16'h0000
`define MMCS_ERR_PPAR    6
`define MMCS_ERR_LPAR    1
`define MMCS_DROP_SERIAL 8'hc9
`define MMCS_DROP_LINE   8'hca
`define MMCS_DROP_HOPS   8'hce
`define MMCS_CLK_HZ      64'd100000000
`define MMCS_WD_TIME_S   64'd30
`define MMCS_RETRY_MIN   64'd3
`define MMCS_SEC_PER_MIN 64'd60
`define MMCS_FIFO_W      10
`define MMCS_FIFO_D      4
`endif

/* core/mmcs_pkg.sv */
package mmcs_pkg;
  // Decoded parity selection for a port.
  typedef enum logic [1:0] {
    PAR_EVEN = 2'b00,
    PAR_ODD  = 2'b01,
    PAR_NONE = 2'b10
  } mmcs_par_type;
  // Watchdog dialing states.
  typedef enum logic [1:0] {
    WD_IDLE  = 2'b00,
    WD_DIAL  = 2'b01,
    WD_LINK  = 2'b10,
    WD_RETRY = 2'b11
  } mmcs_wd_type;
endpackage

/* testbench/mmcs_mode_monitor.sv */
`timescale 1ns/10ps
// Ties the status word and the decoded outputs to the settings that cause them.
module mmcs_mode_monitor
  import mmcs_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         reset_n,
  input wire logic [15:0]  modeCommandWord,
  input wire logic [15:0]  modeStateWord,
  input wire logic [15:0]  errorFlags,
  input wire logic         dialInput,
  input wire logic         pushTalkRelay,
  input wire logic         offHook,
  input wire logic         autoDialRequest,
  input wire mmcs_par_type portParity,
  input wire mmcs_par_type lineParity,
  input wire logic         portCrc,
  input wire logic         lineCrc,
  input wire logic         verdictValid,
  input wire logic         verdictReady,
  input wire logic         verdictLocal,
  input wire logic         verdictToLine
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  relay_echo_a: assert property (pushTalkRelay == modeStateWord[5]
    && pushTalkRelay == modeCommandWord[5]) else $error("relay differs from its bit");
  mdrop_legal_a: assert property (modeStateWord[2] |-> modeStateWord[3]
    && modeStateWord[13]) else $error("multidrop shown outside transparent leased");
  port_par_a: assert property (!modeStateWord[3] && !(&modeStateWord[8:7])
    |-> portParity == {modeStateWord[7], modeStateWord[8]})
    else $error("port parity differs from status");
  line_par_a: assert property (!modeStateWord[3] && !(&modeStateWord[10:9])
    |-> lineParity == {modeStateWord[9], modeStateWord[10]})
    else $error("line parity differs from status");
  line_follow_a: assert property (modeStateWord[3] |-> lineParity == portParity)
    else $error("line parity not following port");
  par_fallback_a: assert property ($rose(errorFlags[6]) |-> portParity == PAR_EVEN)
    else $error("invalid port parity not even");
  line_fallback_a: assert property ($rose(errorFlags[1]) |-> lineParity == PAR_EVEN)
    else $error("invalid line parity not even");
  crc_echo_a: assert property (portCrc == modeStateWord[11]
    && lineCrc == modeStateWord[12]) else $error("checksum differs from status");
  dial_status_a: assert property (dialInput != $past(dialInput)
    |-> ##[1:3] modeStateWord[6] == dialInput) else $error("dial input not shown");
  ring_clear_a: assert property ($rose(offHook) |-> ##[1:2] !modeStateWord[15])
    else $error("ring indicator kept off hook");
  hook_status_a: assert property ($rose(offHook) && !modeStateWord[13]
    |-> ##[0:2] modeStateWord[14]) else $error("hook state not shown");
  dial_pulse_a: assert property (autoDialRequest |=> !autoDialRequest
    && (offHook || modeStateWord[13])) else $error("auto dial did not go off hook");
  verdict_hold_a: assert property (verdictValid && !verdictReady |=> verdictValid
    && $stable(verdictLocal) && $stable(verdictToLine)) else $error("verdict dropped early");
endmodule

bind mmcs_modem_mode mmcs_mode_monitor mon (.clk_sys(clk_sys), .reset_n(reset_n),
  .modeCommandWord(modeCommandWord), .modeStateWord(modeStateWord),
  .errorFlags(errorFlags), .dialInput(dialInput), .pushTalkRelay(pushTalkRelay),
  .offHook(offHook), .autoDialRequest(autoDialRequest), .portParity(portParity),
  .lineParity(lineParity), .portCrc(portCrc), .lineCrc(lineCrc),
  .verdictValid(verdictValid), .verdictReady(verdictReady),
  .verdictLocal(verdictLocal), .verdictToLine(verdictToLine));

/* testbench/mmcs_route_peer.sv */
`timescale 1ns/10ps
// Far side of the route stream: offers drops and takes verdicts, stalling on demand.
module mmcs_route_peer (
  input  wire logic       clk_sys,
  output logic            dropValid,
  input  wire logic       dropReady,
  output logic [7:0]      dropData,
  output logic            dropLast,
  output logic            dropFromLine,
  input  wire logic       verdictValid,
  output logic            verdictReady,
  input  wire logic       verdictLocal,
  input  wire logic       verdictToLine
);
  logic       stall;
  logic       refused;
  logic       stuck;
  logic [1:0] got[$];
  // Idle values; released data shows the inverse of the last word.
  initial begin
    stall = 0;
    refused = 0;
    stuck = 0;
    dropValid = 0;
    dropData = 8'h00;
    dropLast = 0;
    dropFromLine = 0;
  end
  assign verdictReady = !stall;
  // Records every verdict taken.
  always @(posedge clk_sys) begin
    if (verdictValid && verdictReady) got.push_back({verdictLocal, verdictToLine});
  end
  // Holds one drop until it is taken or 200 cycles have passed.
  task automatic send_drop(input logic fl, input logic [7:0] d, input logic last);
    int n;
    dropValid = 1;
    dropData = d;
    dropLast = last;
    dropFromLine = fl;
    n = 0;
    // Ready depends on queue state only, so its settled value holds until the next edge.
    while (!dropReady && n < 200) begin
      refused = 1;
      n++;
      @(posedge clk_sys);
      #1;
    end
    if (n == 200) stuck = 1;
    @(posedge clk_sys);
    #1;
  endtask
  // Sends a two-drop route and then releases the stream.
  task automatic send_route(input logic fl, input logic [7:0] d0, input logic [7:0] d1);
    @(posedge clk_sys);
    #1;
    send_drop(fl, d0, 1'b0);
    send_drop(fl, d1, 1'b1);
    dropValid = 0;
    dropData = ~d1;
    dropLast = 0;
  endtask
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
// Drives the mode block through its settings and judges what it reports.
module tb_top;
  import mmcs_pkg::*;
  logic         clk_sys, reset_n, rackCmdWrite, portCmdWrite, lineCmdWrite;
  logic [15:0]  powerUpSettings, rackCmdData, portCmdData, lineCmdData;
  logic         carrierDetect, clearToSend, dialInput, dialFailed, hangupRequest;
  logic         ringing, ringPulse, atDetectValid;
  logic [1:0]   atDetectParity;
  logic [15:0]  modeCommandWord, modeStateWord, errorFlags;
  logic         setupDefaulted, pushTalkRelay, rtsEnable, offHook, autoDialRequest;
  logic         leasedAnswerMode, carrierSeqStart, portCrc, lineCrc;
  mmcs_par_type portParity, lineParity;
  logic         dropValid, dropReady, dropLast, dropFromLine;
  logic [7:0]   dropData;
  logic         verdictValid, verdictReady, verdictLocal, verdictToLine;
  int           badCount, comparisons;

  mmcs_modem_mode #(.WD_CYC(64'd20), .RETRY_CYC(64'd50)) uut (.clk_sys(clk_sys),
    .reset_n(reset_n), .powerUpSettings(powerUpSettings), .rackCmdWrite(rackCmdWrite),
    .rackCmdData(rackCmdData), .portCmdWrite(portCmdWrite), .portCmdData(portCmdData),
    .lineCmdWrite(lineCmdWrite), .lineCmdData(lineCmdData),
    .modeCommandWord(modeCommandWord), .modeStateWord(modeStateWord),
    .errorFlags(errorFlags), .setupDefaulted(setupDefaulted),
    .carrierDetect(carrierDetect), .clearToSend(clearToSend), .dialInput(dialInput),
    .dialFailed(dialFailed), .hangupRequest(hangupRequest), .ringing(ringing),
    .ringPulse(ringPulse), .ringsToAnswer(8'h02), .atDetectValid(atDetectValid),
    .atDetectParity(atDetectParity), .pushTalkRelay(pushTalkRelay), .rtsEnable(rtsEnable),
    .offHook(offHook), .autoDialRequest(autoDialRequest),
    .leasedAnswerMode(leasedAnswerMode), .carrierSeqStart(carrierSeqStart),
    .portParity(portParity), .lineParity(lineParity), .portCrc(portCrc),
    .lineCrc(lineCrc), .dropValid(dropValid), .dropReady(dropReady),
    .dropData(dropData), .dropLast(dropLast), .dropFromLine(dropFromLine),
    .hopCount(8'h03), .verdictValid(verdictValid), .verdictReady(verdictReady),
    .verdictLocal(verdictLocal), .verdictToLine(verdictToLine));
  mmcs_route_peer peer (.clk_sys(clk_sys), .dropValid(dropValid), .dropReady(dropReady),
    .dropData(dropData), .dropLast(dropLast), .dropFromLine(dropFromLine),
    .verdictValid(verdictValid), .verdictReady(verdictReady),
    .verdictLocal(verdictLocal), .verdictToLine(verdictToLine));

  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    if (badCount == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up();
    badCount++;
    $display("[FAIL] %0t wait ran out", $time);
    tally_and_finish();
  endtask
  // One write strobe from a source (0 rack, 1 port, 2 line), then the two-edge answer.
  task automatic wr(input int src, input logic [15:0] d);
    rackCmdData = d;
    portCmdData = d;
    lineCmdData = d;
    rackCmdWrite = (src == 0);
    portCmdWrite = (src == 1);
    lineCmdWrite = (src == 2);
    tick(1);
    rackCmdWrite = 0;
    portCmdWrite = 0;
    lineCmdWrite = 0;
    tick(2);
  endtask
  task automatic pulse_ring(input int n);
    repeat (n) begin
      ringPulse = 1;
      tick(1);
      ringPulse = 0;
      tick(1);
    end
  endtask
  // Special drops with the verdict side stalled for 40 cycles, by which time the queue must have refused.
  task automatic s_drops();
    logic [7:0] d0[6] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h03, 8'h02};
    logic [7:0] d1[6] = '{8'hc9, 8'hc9, 8'hca, 8'hca, 8'hce, 8'hce};
    logic [5:0] fl = 6'b010110;
    logic [1:0] ex[6] = '{2'b11, 2'b00, 2'b10, 2'b01, 2'b10, 2'b01};
    peer.stall = 1;
    fork
      for (int i = 0; i < 6; i++) peer.send_route(fl[i], d0[i], d1[i]);
      begin
        tick(40);
        check1(peer.refused, 1'b1);
        peer.stall = 0;
      end
    join
    if (peer.stuck) give_up();
    tick(20);
    check16(16'(peer.got.size()), 16'h0006);
    for (int i = 0; i < 6 && i < peer.got.size(); i++) begin
      check16(16'(peer.got[i]), 16'(ex[i]));
    end
  endtask
  task automatic s_fields();
    clearToSend = 1;
    wr(0, 16'h1b20);
    check16(modeStateWord, 16'h1b22);
    check1(portParity === PAR_ODD && lineParity === PAR_NONE, 1'b1);
    check1(portCrc && lineCrc && pushTalkRelay, 1'b1);
    wr(0, 16'h1fa0);
    check1(portParity === PAR_EVEN && errorFlags[6] === 1'b1, 1'b1);
    check1(lineParity === PAR_EVEN && errorFlags[1] === 1'b1, 1'b1);
  endtask
  task automatic s_sources();
    wr(1, 16'h0020);
    wr(1, 16'h0000);
    check1(pushTalkRelay, 1'b0);
    wr(0, 16'h1fa0);
    check1(pushTalkRelay, 1'b0);
    wr(2, 16'h0020);
    check1(modeStateWord[5], 1'b1);
  endtask
  // Transparent mode takes the detected parity on both ports.
  task automatic s_transparent();
    wr(0, 16'h0008);
    atDetectParity = 2'b01;
    atDetectValid = 1;
    tick(1);
    atDetectValid = 0;
    tick(2);
    check1(portParity === PAR_ODD && lineParity === PAR_ODD, 1'b1);
    check1(errorFlags[6], 1'b0);
  endtask
  task automatic s_multidrop();
    logic [15:0] w[7] = '{16'h200c, 16'h2004, 16'h200c, 16'h000c, 16'h200c, 16'h0008, 16'h000c};
    logic [6:0]  e = 7'b0000101;
    for (int i = 0; i < 7; i++) begin
      wr(0, w[i]);
      check1(modeStateWord[2], e[i]);
    end
  endtask
  task automatic s_answer();
    int n;
    wr(0, 16'h0000);
    ringing = 1;
    tick(3);
    check1(modeStateWord[15], 1'b1);
    pulse_ring(2);
    n = 0;
    while (offHook !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    if (n == 10) give_up();
    tick(3);
    check16({modeStateWord[15:14], 14'h0}, 16'h4000);
    ringing = 0;
    hangupRequest = 1;
    tick(1);
    hangupRequest = 0;
    tick(3);
    wr(0, 16'h0010);
    ringing = 1;
    pulse_ring(3);
    tick(3);
    check1(offHook, 1'b0);
    ringing = 0;
    tick(3);
    check1(modeStateWord[15], 1'b0);
    wr(0, 16'h2000);
    check1(leasedAnswerMode, 1'b1);
    wr(0, 16'h2010);
    check1(leasedAnswerMode, 1'b0);
    check1(carrierSeqStart, 1'b1);
    wr(0, 16'h6010);
    check1(modeStateWord[14], 1'b1);
  endtask
  task automatic s_watchdog();
    int n;
    dialInput = 1;
    tick(3);
    check1(modeStateWord[6], 1'b1);
    wr(0, 16'h0050);
    dialInput = 0;
    n = 0;
    while (autoDialRequest !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    if (n == 60) give_up();
    check1(n >= 17 && n <= 23, 1'b1);
    tick(1);
    check1(offHook, 1'b1);
    dialFailed = 1;
    tick(1);
    dialFailed = 0;
    n = 0;
    while (autoDialRequest !== 1'b1 && n < 120) begin
      tick(1);
      n++;
    end
    if (n == 120) give_up();
    check1(n >= 45, 1'b1);
    carrierDetect = 1;
    tick(2);
    repeat (60) begin
      tick(1);
      check1(autoDialRequest, 1'b0);
    end
    check1(modeStateWord[0], 1'b1);
  endtask
  task automatic s_powerup();
    reset_n = 0;
    powerUpSettings = 16'h0004;
    tick(2);
    reset_n = 1;
    tick(3);
    check1(setupDefaulted, 1'b1);
    check16(modeCommandWord, 16'h0000);
  endtask
  // Main sequence.
  initial begin
    badCount = 0;
    comparisons = 0;
    reset_n = 0;
    powerUpSettings = 16'h0000;
    {rackCmdWrite, portCmdWrite, lineCmdWrite} = 3'b000;
    {rackCmdData, portCmdData, lineCmdData} = '0;
    {carrierDetect, clearToSend, dialInput, dialFailed} = 4'b0000;
    {hangupRequest, ringing, ringPulse} = 3'b000;
    {atDetectValid, atDetectParity} = 3'b000;
    tick(2);
    reset_n = 1;
    tick(2);
    s_drops();
    s_fields();
    s_sources();
    s_transparent();
    s_multidrop();
    s_answer();
    s_watchdog();
    s_powerup();
    tally_and_finish();
  end
endmodule
